/* File: rtl/clk_mon.sv */
// input clock validation monitor: oscillator and per-reference checks
// assumes reference and oscillator pins are asynchronous; timing in sys cycles except the ppm gate, counted in oscillator edges
// Operation
// (R1) never enable ppm and pps detectors together
// (R2) oscillator flag clear only within 9-160 MHz; above half the sys clock the edge count aliases and can clear it
// (R3) bypass makes loop treat oscillator valid
// (R4) bypass leaves oscillator loss flag untouched
// (R5) each reference has independent monitors
// (R6) pps reference uses only phase monitor
// (R7) qualify after flags clear for timer duration
// (R8) enables, thresholds, timer programmable per input
// (R9) disabled monitor never flags, ignored
// (R10) pins show all inputs, status selected only
// (R11) ppm error measured against oscillator
// (R12) ppm flag has valid/invalid hysteresis
// (R13) longer averaging slows flag, limits threshold
// (R14) late window sets missing flag
// (R15) missing monitor only 2 kHz to f/12
// (R16) missing and runt share window, OR'd
// (R17) early pulse sets runt flag at once
// (R18) runt monitor only 2 kHz to f/12
// (R19) early detect only with late detect
// (R20) late threshold above longest period
// (R21) early threshold below shortest period
// (R22) pps window sets flag when late
// (R23) any flag disqualifies, restarts timer
`default_nettype none
module clk_mon
    import clk_mon_pkg::*;
(
    // system
    input wire logic clk_sys,
    input wire logic rst,
    // clock pins
    input wire logic osc_in,
    input wire logic [num_refs-1:0] ref_in,
    // oscillator control and status
    input wire logic osc_detect_bypass,
    output logic osc_loss_flag,
    output logic osc_valid,
    // per-reference enables
    input wire logic [num_refs-1:0] freq_mon_en,
    input wire logic [num_refs-1:0] late_mon_en,
    input wire logic [num_refs-1:0] early_mon_en,
    input wire logic [num_refs-1:0] pps_mon_en,
    input wire logic [num_refs-1:0] vtimer_en,
    // per-reference settings, flattened
    input wire logic [num_refs*cnt_width-1:0] nominal_period,
    input wire logic [num_refs*cnt_width-1:0] late_thresh,
    input wire logic [num_refs*cnt_width-1:0] early_thresh,
    input wire logic [num_refs*cnt_width-1:0] pps_jitter_margin,
    input wire logic [num_refs*cnt_width-1:0] vtimer_cycles,
    input wire logic [num_refs*cnt_width-1:0] freq_gate_osc,
    input wire logic [num_refs*cnt_width-1:0] freq_expect,
    input wire logic [num_refs*cnt_width-1:0] freq_valid_thresh,
    input wire logic [num_refs*cnt_width-1:0] freq_invalid_thresh,
    // loop selection
    input wire logic [sel_width-1:0] loop_sel,
    // status pins, all inputs
    output logic [num_refs-1:0] ref_freq_error_flag,
    output logic [num_refs-1:0] ref_window_flag,
    output logic [num_refs-1:0] ref_pps_flag,
    output logic [num_refs-1:0] ref_qualified,
    // status bits, selected input
    output logic sel_freq_error,
    output logic sel_window_flag,
    output logic sel_pps_flag,
    output logic sel_qualified
);

    function automatic logic [cnt_width-1:0] field(
        input logic [num_refs*cnt_width-1:0] bus,
        input int unsigned idx
    );
        field = bus[idx*cnt_width +: cnt_width];
    endfunction : field

    function automatic logic [cnt_width-1:0] abs_diff(
        input logic [cnt_width-1:0] a,
        input logic [cnt_width-1:0] b
    );
        abs_diff = (a > b) ? a - b : b - a;
    endfunction : abs_diff

    // window end from the last edge; clamps instead of wrapping past the top
    function automatic logic [cnt_width-1:0] win_limit(
        input logic [cnt_width-1:0] base,
        input logic [cnt_width-1:0] offs
    );
        logic [cnt_width:0] sum;
        sum = {1'b0, base} + {1'b0, offs};
        win_limit = sum[cnt_width] ? {cnt_width{1'b1}} : sum[cnt_width-1:0];
    endfunction : win_limit

    function automatic logic [cnt_width-1:0] sat_sub(
        input logic [cnt_width-1:0] a,
        input logic [cnt_width-1:0] b
    );
        sat_sub = (a > b) ? a - b : count_zero;
    endfunction : sat_sub

    // ------------------------------------------------------------
    // synchronisers and edge detect
    // ------------------------------------------------------------
    logic osc_s1_q, osc_s2_q, osc_s3_q;
    logic [num_refs-1:0] ref_s1_q, ref_s2_q, ref_s3_q;
    logic osc_edge;
    logic [num_refs-1:0] ref_edge;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
            ref_s1_q <= '0;
            ref_s2_q <= '0;
            ref_s3_q <= '0;
        end else begin
            osc_s1_q <= osc_in;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            ref_s1_q <= ref_in;
            ref_s2_q <= ref_s1_q;
            ref_s3_q <= ref_s2_q;
        end
    end

    assign osc_edge = osc_s2_q & ~osc_s3_q;
    assign ref_edge = ref_s2_q & ~ref_s3_q;

    // ------------------------------------------------------------
    // coarse oscillator frequency check
    // ------------------------------------------------------------
    logic [15:0] osc_gate_q, osc_gate_d, osc_cnt_q, osc_cnt_d;
    logic osc_loss_q, osc_loss_d, osc_valid_q, osc_valid_d;
    // edges pass the synchroniser, so an oscillator above half the system
    // clock aliases; the upper bound only holds for what can be sampled

    always_comb begin
        osc_gate_d = osc_gate_q + 16'h0001;
        osc_cnt_d = osc_cnt_q + {15'h0000, osc_edge};
        osc_loss_d = osc_loss_q;
        if (osc_gate_q == osc_gate_count - 16'h0001) begin
            osc_gate_d = 16'h0000;
            osc_cnt_d = 16'h0000;
            osc_loss_d = !(osc_cnt_q >= osc_min_count && osc_cnt_q <= osc_max_count); // (R2)
        end
        osc_valid_d = osc_detect_bypass | ~osc_loss_d; // (R3) (R4)
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            osc_gate_q <= 16'h0000;
            osc_cnt_q <= 16'h0000;
            osc_loss_q <= 1'b1;
            osc_valid_q <= 1'b0;
        end else begin
            osc_gate_q <= osc_gate_d;
            osc_cnt_q <= osc_cnt_d;
            osc_loss_q <= osc_loss_d;
            osc_valid_q <= osc_valid_d;
        end
    end

    // ------------------------------------------------------------
    // per-reference monitors
    // ------------------------------------------------------------
    logic [cnt_width-1:0] win_q [num_refs];
    logic [cnt_width-1:0] win_d [num_refs];
    logic [cnt_width-1:0] fosc_q [num_refs];
    logic [cnt_width-1:0] fosc_d [num_refs];
    logic [cnt_width-1:0] fref_q [num_refs];
    logic [cnt_width-1:0] fref_d [num_refs];
    logic [cnt_width-1:0] vt_q [num_refs];
    logic [cnt_width-1:0] vt_d [num_refs];
    logic [num_refs-1:0] late_q, late_d, early_q, early_d;
    logic [num_refs-1:0] pps_q, pps_d, freq_q, freq_d, qual_q, qual_d;

    always_comb begin
        for (int i = 0; i < num_refs; i++) begin // (R5) (R8)
            logic [cnt_width-1:0] err;
            logic any_flag;
            err = abs_diff(fref_q[i], field(freq_expect, i));
            any_flag = 1'b0;
            win_d[i] = win_q[i] + count_one;
            late_d[i] = late_q[i];
            early_d[i] = early_q[i];
            pps_d[i] = pps_q[i];
            fosc_d[i] = fosc_q[i] + {31'h0000_0000, osc_edge};
            fref_d[i] = fref_q[i] + {31'h0000_0000, ref_edge[i]};
            freq_d[i] = freq_q[i];
            // shared window: early and late share one counter
            if (ref_edge[i]) begin
                win_d[i] = count_zero;
                late_d[i] = 1'b0; // (R14)
                early_d[i] = win_q[i] <
                    sat_sub(field(nominal_period, i), field(early_thresh, i)); // (R17)
                pps_d[i] = 1'b0; // (R22)
            end else begin
                if (win_q[i] >= win_limit(field(nominal_period, i), field(late_thresh, i)))
                    late_d[i] = 1'b1; // (R14)
                if (win_q[i] >= win_limit(field(nominal_period, i), field(pps_jitter_margin, i)))
                    pps_d[i] = 1'b1; // (R22)
                if (win_q[i] == '1)
                    win_d[i] = win_q[i];
            end
            // ppm detector: ref edges over a gate of oscillator edges
            if (fosc_q[i] >= field(freq_gate_osc, i)) begin // (R11) (R13)
                fosc_d[i] = count_zero;
                fref_d[i] = count_zero;
                if (err < field(freq_valid_thresh, i))
                    freq_d[i] = 1'b0; // (R12)
                else if (err > field(freq_invalid_thresh, i))
                    freq_d[i] = 1'b1; // (R12)
            end
            // disabled monitors hold their flag clear
            if (!late_mon_en[i]) late_d[i] = 1'b0; // (R9)
            if (!(early_mon_en[i] && late_mon_en[i])) early_d[i] = 1'b0; // (R9) (R19)
            if (!pps_mon_en[i]) pps_d[i] = 1'b0; // (R9)
            if (!freq_mon_en[i]) freq_d[i] = 1'b0; // (R9)
            any_flag = late_d[i] | early_d[i] | pps_d[i] | freq_d[i];
            vt_d[i] = vt_q[i];
            qual_d[i] = qual_q[i];
            if (any_flag) begin
                vt_d[i] = count_zero; // (R23)
                qual_d[i] = 1'b0; // (R23)
            end else if (!vtimer_en[i]) begin
                qual_d[i] = 1'b1;
            end else if (vt_q[i] >= field(vtimer_cycles, i)) begin
                qual_d[i] = 1'b1; // (R7)
            end else begin
                vt_d[i] = vt_q[i] + count_one; // (R7)
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < num_refs; i++) begin
                win_q[i] <= count_zero;
                fosc_q[i] <= count_zero;
                fref_q[i] <= count_zero;
                vt_q[i] <= count_zero;
            end
            late_q <= '0;
            early_q <= '0;
            pps_q <= '0;
            freq_q <= '0;
            qual_q <= '0;
        end else begin
            for (int i = 0; i < num_refs; i++) begin
                win_q[i] <= win_d[i];
                fosc_q[i] <= fosc_d[i];
                fref_q[i] <= fref_d[i];
                vt_q[i] <= vt_d[i];
            end
            late_q <= late_d;
            early_q <= early_d;
            pps_q <= pps_d;
            freq_q <= freq_d;
            qual_q <= qual_d;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    logic [num_refs-1:0] winf_q, winf_d;
    logic sel_f_q, sel_w_q, sel_p_q, sel_q_q;
    logic sel_f_d, sel_w_d, sel_p_d, sel_q_d;

    always_comb begin
        winf_d = late_q | early_q; // (R16)
        sel_f_d = freq_q[loop_sel]; // (R10)
        sel_w_d = winf_d[loop_sel]; // (R10)
        sel_p_d = pps_q[loop_sel]; // (R10)
        sel_q_d = qual_q[loop_sel];
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            winf_q <= '0;
            sel_f_q <= 1'b0;
            sel_w_q <= 1'b0;
            sel_p_q <= 1'b0;
            sel_q_q <= 1'b0;
        end else begin
            winf_q <= winf_d;
            sel_f_q <= sel_f_d;
            sel_w_q <= sel_w_d;
            sel_p_q <= sel_p_d;
            sel_q_q <= sel_q_d;
        end
    end

    assign osc_loss_flag = osc_loss_q;
    assign osc_valid = osc_valid_q;
    assign ref_freq_error_flag = freq_q;
    assign ref_window_flag = winf_q;
    assign ref_pps_flag = pps_q;
    assign ref_qualified = qual_q;
    assign sel_freq_error = sel_f_q;
    assign sel_window_flag = sel_w_q;
    assign sel_pps_flag = sel_p_q;
    assign sel_qualified = sel_q_q;

endmodule : clk_mon
`default_nettype wire

/* File: rtl/clk_mon_pkg.sv */
// package: constants for the input clock validation monitor
// assumes a 125 MHz system clock that counts every reference edge
`default_nettype none
package clk_mon_pkg;
    localparam int unsigned num_refs = 4;
    localparam int unsigned cnt_width = 32;
    localparam int unsigned sel_width = 2;
    localparam int unsigned clk_mhz = 125;
    // coarse oscillator range in kHz, measured over a gate of sys cycles
    localparam int unsigned osc_min_khz = 9000;
    localparam int unsigned osc_max_khz = 160000;
    localparam int unsigned osc_gate_us = 8;
    localparam int unsigned osc_gate_cycles = osc_gate_us * clk_mhz;
    localparam logic [15:0] osc_min_count = 16'(osc_min_khz * osc_gate_us / 1000);
    localparam logic [15:0] osc_max_count = 16'(osc_max_khz * osc_gate_us / 1000);
    localparam logic [15:0] osc_gate_count = 16'(osc_gate_cycles);
    localparam logic [cnt_width-1:0] count_zero = 32'h0000_0000;
    localparam logic [cnt_width-1:0] count_one = 32'h0000_0001;
endpackage : clk_mon_pkg
`default_nettype wire

/* File: verification/clk_mon_sva.sv */
// checker: flag and qualification relations at the monitor ports
// assumes a bind onto clk_mon
`default_nettype none
module clk_mon_chk
    import clk_mon_pkg::*;
(
    // system
    input wire logic clk_sys,
    input wire logic rst,
    // oscillator
    input wire logic osc_detect_bypass,
    input wire logic osc_loss_flag,
    input wire logic osc_valid,
    // per-reference control
    input wire logic [num_refs-1:0] freq_mon_en,
    input wire logic [num_refs-1:0] late_mon_en,
    input wire logic [num_refs-1:0] pps_mon_en,
    input wire logic [num_refs-1:0] vtimer_en,
    input wire logic [num_refs*cnt_width-1:0] vtimer_cycles,
    input wire logic [sel_width-1:0] loop_sel,
    // status
    input wire logic [num_refs-1:0] ref_freq_error_flag,
    input wire logic [num_refs-1:0] ref_window_flag,
    input wire logic [num_refs-1:0] ref_pps_flag,
    input wire logic [num_refs-1:0] ref_qualified,
    input wire logic sel_window_flag,
    input wire logic sel_qualified
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // cycles since reference 0 last showed a flag
    logic [cnt_width-1:0] clear_q, clear_d;
    always_comb begin
        clear_d = clear_q + 32'h1;
        if (ref_window_flag[0] || ref_freq_error_flag[0] || ref_pps_flag[0]) begin
            clear_d = 32'h0;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clear_q <= 32'h0;
        end else begin
            clear_q <= clear_d;
        end
    end
    bypass_valid_a: assert property (osc_detect_bypass |=> osc_valid)
        else $error("bypass did not force valid");
    loss_invalid_a: assert property (!osc_detect_bypass |=> osc_valid == !osc_loss_flag)
        else $error("valid disagrees with loss");
    sel_qual_a: assert property (($stable(loop_sel) && $stable(ref_qualified)) [*2]
        |-> sel_qualified == ref_qualified[loop_sel]) else $error("selected qualify wrong");
    sel_window_a: assert property (($stable(loop_sel) && $stable(ref_window_flag)) [*2]
        |-> sel_window_flag == ref_window_flag[loop_sel]) else $error("selected window wrong");
    qual_wait_a: assert property ($rose(ref_qualified[0]) && vtimer_en[0]
        |-> clear_q + 32'h1 >= vtimer_cycles[31:0]) else $error("qualified too early");
    for (genvar i = 0; i < num_refs; i++) begin : g_ref
        freq_off_a: assert property (!freq_mon_en[i] [*3] |-> !ref_freq_error_flag[i])
            else $error("disabled freq monitor flagged");
        window_off_a: assert property (!late_mon_en[i] [*3] |-> !ref_window_flag[i])
            else $error("disabled window monitor flagged");
        pps_off_a: assert property (!pps_mon_en[i] [*3] |-> !ref_pps_flag[i])
            else $error("disabled pps monitor flagged");
        flag_drop_a: assert property ($rose(ref_window_flag[i] || ref_freq_error_flag[i]
            || ref_pps_flag[i]) |=> !ref_qualified[i]) else $error("flag kept qualified");
    end
    cover property ($rose(ref_window_flag[0]));
    cover property ($rose(ref_qualified[0]));
    cover property ($fell(osc_loss_flag));
endmodule : clk_mon_chk
bind clk_mon clk_mon_chk chk (.clk_sys, .rst, .osc_detect_bypass, .osc_loss_flag, .osc_valid,
    .freq_mon_en, .late_mon_en, .pps_mon_en, .vtimer_en, .vtimer_cycles, .loop_sel,
    .ref_freq_error_flag, .ref_window_flag, .ref_pps_flag, .ref_qualified,
    .sel_window_flag, .sel_qualified);
`default_nettype wire

/* File: verification/ref_clk_source.sv */
// source model: oscillator and reference pulse trains
// assumes settings in ns; a zero reference period stops that pin low
`default_nettype none
module ref_clk_source (
    // settings
    input wire logic [15:0] osc_half_ns,
    input wire logic [63:0] ref_per_ns,
    // clock pins
    output logic osc_in,
    output logic [3:0] ref_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial osc_in = 1'b0;
    always #(osc_half_ns) osc_in = ~osc_in;
    for (genvar i = 0; i < 4; i++) begin : g_ref
        initial begin
            logic [15:0] per;
            ref_in[i] = 1'b0;
            forever begin
                // period latched per pulse so a change mid-pulse cannot underflow
                per = ref_per_ns[16*i+:16];
                if (per == 16'h0) begin
                    #8;
                end else begin
                    ref_in[i] = 1'b1;
                    #24;
                    ref_in[i] = 1'b0;
                    #(per - 16'h18);
                end
            end
        end
    end
endmodule : ref_clk_source
`default_nettype wire

/* File: verification/tb_clk_mon.sv */
// self-checking bench for the clock validation monitor
// assumes the source model makes every clock pin
`default_nettype none
module tb_clk_mon
    import clk_mon_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic osc_detect_bypass = 1'b0;
    logic [3:0] freq_mon_en = 4'h0, late_mon_en = 4'h0, early_mon_en = 4'h0;
    logic [3:0] pps_mon_en = 4'h0, vtimer_en = 4'h0;
    logic [127:0] nominal_period = {64'h0, 32'h64, 32'h50};
    logic [127:0] late_thresh = {96'h0, 32'hA};
    logic [127:0] early_thresh = {96'h0, 32'hA};
    logic [127:0] pps_jitter_margin = {64'h0, 32'hA, 32'h0};
    logic [127:0] vtimer_cycles = {96'h0, 32'hC8};
    logic [127:0] freq_gate_osc = {32'h0, 32'h1F4, 64'h0};
    logic [127:0] freq_expect = {32'h0, 32'h10, 64'h0};
    logic [127:0] freq_valid_thresh = {32'h0, 32'h2, 64'h0};
    logic [127:0] freq_invalid_thresh = {32'h0, 32'h4, 64'h0};
    logic [1:0] loop_sel = 2'h0;
    logic [15:0] osc_half_ns = 16'hA;
    logic [63:0] ref_per_ns = 64'h0;
    logic osc_in, osc_loss_flag, osc_valid, sel_freq_error, sel_window_flag, sel_pps_flag;
    logic sel_qualified;
    logic [3:0] ref_in, ref_freq_error_flag, ref_window_flag, ref_pps_flag, ref_qualified;
    int miscompares = 0;
    int checked = 0;
    always #4 clk_sys = ~clk_sys;
    ref_clk_source src (.osc_half_ns, .ref_per_ns, .osc_in, .ref_in);
    clk_mon DUT (.clk_sys, .rst, .osc_in, .ref_in, .osc_detect_bypass, .osc_loss_flag,
        .osc_valid, .freq_mon_en, .late_mon_en, .early_mon_en, .pps_mon_en, .vtimer_en,
        .nominal_period, .late_thresh, .early_thresh, .pps_jitter_margin, .vtimer_cycles,
        .freq_gate_osc, .freq_expect, .freq_valid_thresh, .freq_invalid_thresh, .loop_sel,
        .ref_freq_error_flag, .ref_window_flag, .ref_pps_flag, .ref_qualified,
        .sel_freq_error, .sel_window_flag, .sel_pps_flag, .sel_qualified);
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic step_ref(input int i, input logic [15:0] ns, input int n);
        @(posedge clk_sys);
        ref_per_ns[16*i+:16] <= ns;
        cyc(n);
    endtask : step_ref
    task automatic check(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : check
    task automatic finish_test();
        $display("compares %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    task automatic test_osc();
        cyc(2100);
        check(osc_loss_flag, 1'b0, "loss at 50 MHz");
        check(osc_valid, 1'b1, "valid at 50 MHz");
        @(posedge clk_sys);
        osc_half_ns <= 16'h64;
        cyc(2100);
        check(osc_loss_flag, 1'b1, "loss at 5 MHz");
        check(osc_valid, 1'b0, "invalid at 5 MHz");
        @(posedge clk_sys);
        osc_detect_bypass <= 1'b1;
        cyc(3);
        check(osc_loss_flag, 1'b1, "loss under bypass");
        check(osc_valid, 1'b1, "valid under bypass");
        @(posedge clk_sys);
        osc_half_ns <= 16'hA;
        cyc(2100);
        check(osc_loss_flag, 1'b0, "loss recovers under bypass");
        @(posedge clk_sys);
        osc_detect_bypass <= 1'b0;
        $display("osc test done");
    endtask : test_osc
    task automatic test_window();
        @(posedge clk_sys);
        late_mon_en[0] <= 1'b1;
        early_mon_en[0] <= 1'b1;
        vtimer_en[0] <= 1'b1;
        step_ref(0, 16'h280, 400);
        check(ref_window_flag[0], 1'b0, "window steady");
        check(sel_qualified, 1'b1, "qualified steady");
        step_ref(0, 16'h0, 120);
        check(ref_window_flag[0], 1'b1, "window missing");
        check(ref_qualified[0], 1'b0, "disqualified missing");
        step_ref(0, 16'h280, 100);
        check(ref_window_flag[0], 1'b0, "window back");
        check(ref_qualified[0], 1'b0, "timer restarted");
        cyc(150);
        check(ref_qualified[0], 1'b1, "requalified");
        step_ref(0, 16'h190, 200);
        check(sel_window_flag, 1'b1, "runt pulses");
        @(posedge clk_sys);
        late_mon_en[0] <= 1'b0;
        cyc(10);
        check(ref_window_flag[0], 1'b0, "early alone");
        $display("window test done");
    endtask : test_window
    task automatic test_pps();
        @(posedge clk_sys);
        pps_mon_en[1] <= 1'b1;
        loop_sel <= 2'h1;
        step_ref(1, 16'h320, 400);
        check(sel_pps_flag, 1'b0, "pps steady");
        check(ref_qualified[1], 1'b1, "no timer qualifies");
        step_ref(1, 16'h0, 130);
        check(sel_pps_flag, 1'b1, "pps missing");
        check(ref_pps_flag[0], 1'b0, "other input quiet");
        $display("pps test done");
    endtask : test_pps
    task automatic test_freq();
        @(posedge clk_sys);
        freq_mon_en[2] <= 1'b1;
        loop_sel <= 2'h2;
        step_ref(2, 16'h280, 2800);
        check(sel_freq_error, 1'b0, "freq on target");
        step_ref(2, 16'h190, 2800);
        check(ref_freq_error_flag[2], 1'b1, "freq far off");
        step_ref(2, 16'h210, 2800);
        check(ref_freq_error_flag[2], 1'b1, "freq in hysteresis");
        step_ref(2, 16'h280, 2800);
        check(sel_freq_error, 1'b0, "freq recovered");
        $display("freq test done");
    endtask : test_freq
    initial begin
        #400us;
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        test_osc();
        test_window();
        test_pps();
        test_freq();
        finish_test();
    end
endmodule : tb_clk_mon
`default_nettype wire
